// ### inc/telemetry_pkg.sv
// constants and carrier types of the telemetry text framer
// assumes a 40 MHz system clock and 10-bit sensor conversion codes
package telemetry_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0]  REG_CTRL      = 8'h00;
   localparam logic [7:0]  REG_INTERVAL  = 8'h04;
   localparam logic [7:0]  REG_STATUS    = 8'h08;
   localparam int unsigned CTRL_EN_BIT   = 0;
   localparam int unsigned CTRL_PROF_BIT = 1;
   localparam int unsigned STAT_BUSY_BIT = 8;
   localparam int unsigned STAT_PEND_BIT = 9;
   localparam logic [1:0]  RST_CTRL      = 2'h0;
   localparam logic [15:0] RST_INTERVAL  = 16'h003C;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ      = 40_000_000;
   localparam int unsigned TICK_S      = 1;
   localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_S;
   // ----------------------------------------------------------------
   // report layout
   // ----------------------------------------------------------------
   localparam logic [7:0] CH_T     = 8'h54;
   localparam logic [7:0] CH_HASH  = 8'h23;
   localparam logic [7:0] CH_COMMA = 8'h2C;
   localparam logic [7:0] CH_ZERO  = 8'h30;
   localparam logic [5:0] HDR_LEN  = 6'h02;
   localparam logic [5:0] BITS_POS = 6'h1A;
   localparam logic [5:0] LAST_POS = 6'h21;
   localparam int unsigned ADC_SHIFT = 2;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_EMIT = 1'b1
   } state_t;
   typedef struct packed {
      logic       last;
      logic [7:0] ch;
   } char_beat_t;
   typedef struct packed {
      logic [7:0] seq;
      logic [7:0] temp;
      logic [7:0] supply;
      logic [7:0] ain1;
      logic [7:0] ain2;
      logic [7:0] radio;
      logic       aux;
      logic       prof;
   } sample_t;
endpackage

// ### logic/telemetry_text_framer.sv
// telemetry text framer: builds the periodic text report and a FIFO
// assumes synchronous inputs, one clock, and a byte-wide downstream
// encoder that takes a character on char_valid and char_ready high
//
// Overview of operation
// - if enabled, one report per elapsed interval; none starts when off.
// - report opens with T#, then six three-digit zero-padded fields.
// - each numeric field carries one byte, value 0 to 255.
// - field order: sequence, temperature, supply, input one, two, radio.
// - sequence count rises by one per report sent, wrapping at a byte.
// - temperature count times 1.9608 gives kelvins.
// - supply count divided by 13.84 gives volts.
// - analogue inputs span 0 to 5 V at 51 counts per volt.
// - an eight binary digit field follows; only two low digits used.
// - rightmost binary digit shows the active configuration profile.
// - next binary digit shows the fourth auxiliary digital input.
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// flip-flop FIFO
// ------------------------------------------------------------------
module fifo_buf #(
   parameter int unsigned W     = 9,
   parameter int unsigned DEPTH = 16
) (
   // clock and reset
   input  wire logic         clock,
   input  wire logic         rst,
   // fill side
   input  wire logic         in_valid,
   output logic             in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic             out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]     out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0]   cnt_q, cnt_d;
   logic          push, pop;

   always_comb begin
      in_ready  = cnt_q != (AW+1)'(DEPTH);
      out_valid = cnt_q != '0;
      out_data  = mem_q[rp_q];
      push      = in_valid && in_ready;
      pop       = out_valid && out_ready;
      wp_d      = push ? wp_q + 1'b1 : wp_q;
      rp_d      = pop ? rp_q + 1'b1 : rp_q;
      cnt_d     = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
      end
   end

   // storage carries no reset; it is only read behind the count
   always_ff @(posedge clock) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end
endmodule

// ------------------------------------------------------------------
// report builder
// ------------------------------------------------------------------
module telemetry_text_framer #(
   parameter int unsigned ADC_W       = 10,
   parameter int unsigned FIFO_DEPTH  = 16,
   parameter int unsigned TICK_CYCLES = telemetry_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst,
   // register port
   input  wire logic [7:0]       reg_addr,
   input  wire logic [31:0]      reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic [31:0]           reg_rdata,
   // sensor conversion codes and digital line
   input  wire logic [ADC_W-1:0] temp_adc,
   input  wire logic [ADC_W-1:0] supply_adc,
   input  wire logic [ADC_W-1:0] header_analog_in_first,
   input  wire logic [ADC_W-1:0] header_analog_in_second,
   input  wire logic [ADC_W-1:0] radio_connector,
   input  wire logic             aux_digital_in_fourth,
   // character stream to the packet encoder
   output logic [7:0]            char_data,
   output logic                  char_last,
   output logic                  char_valid,
   input  wire logic             char_ready
);
   localparam int unsigned TW = $clog2(TICK_CYCLES);

   // ----------------------------------------------------------------
   // registers and timers
   // ----------------------------------------------------------------
   logic [1:0]  ctrl_q, ctrl_d;
   logic [15:0] ivl_q, ivl_d, icnt_q, icnt_d;
   logic [31:0] rdata_q, rdata_d;
   logic [TW-1:0] tick_q, tick_d;
   logic          tick, pend_q, pend_d, trig, en;
   telemetry_pkg::state_t     st_q, st_d;
   logic [5:0]                pos_q, pos_d;
   logic [7:0]                seq_q, seq_d;
   telemetry_pkg::sample_t    smp_q, smp_d;
   telemetry_pkg::char_beat_t beat, fout, out_q, out_d;
   logic push, fin_ready, fout_valid, fout_ready, ov_q, ov_d, start;

   assign en = ctrl_q[telemetry_pkg::CTRL_EN_BIT];

   always_comb begin
      ctrl_d  = ctrl_q;
      ivl_d   = ivl_q;
      rdata_d = 32'h0000_0000;
      if (reg_wr && reg_addr == telemetry_pkg::REG_CTRL) begin
         ctrl_d = reg_wdata[1:0];
      end
      if (reg_wr && reg_addr == telemetry_pkg::REG_INTERVAL) begin
         ivl_d = reg_wdata[15:0];
      end
      if (reg_rd) begin
         case (reg_addr)
            telemetry_pkg::REG_CTRL:     rdata_d = {30'h0, ctrl_q};
            telemetry_pkg::REG_INTERVAL: rdata_d = {16'h0, ivl_q};
            telemetry_pkg::REG_STATUS:
               rdata_d = {22'h0, pend_q, st_q == telemetry_pkg::ST_EMIT,
                          seq_q};
            default:                     rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // a seconds tick drives the interval; an interval of zero acts as one
   always_comb begin
      tick   = tick_q == TW'(TICK_CYCLES - 1);
      tick_d = tick ? '0 : tick_q + 1'b1;
      trig   = 1'b0;
      icnt_d = icnt_q;
      if (!en) begin
         icnt_d = '0;
      end else if (tick) begin
         if (icnt_q + 16'h0001 >= ivl_q) begin
            icnt_d = '0;
            trig   = 1'b1;
         end else begin
            icnt_d = icnt_q + 16'h0001;
         end
      end
      start  = st_q == telemetry_pkg::ST_IDLE && pend_q && en;
      // a new trigger wins over the clear by start
      pend_d = en && ((pend_q && !start) || trig);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrl_q  <= telemetry_pkg::RST_CTRL;
         ivl_q   <= telemetry_pkg::RST_INTERVAL;
         rdata_q <= 32'h0000_0000;
         tick_q  <= '0;
         icnt_q  <= '0;
         pend_q  <= 1'b0;
      end else begin
         ctrl_q  <= ctrl_d;
         ivl_q   <= ivl_d;
         rdata_q <= rdata_d;
         tick_q  <= tick_d;
         icnt_q  <= icnt_d;
         pend_q  <= pend_d;
      end
   end
   assign reg_rdata = rdata_q;

   // ----------------------------------------------------------------
   // character generation
   // ----------------------------------------------------------------
   function automatic logic [7:0] digit(input logic [7:0] v,
                                        input logic [1:0] k);
      logic [7:0] d;
      d = 8'h00;
      case (k)
         2'h0:    d = v / 8'h64;
         2'h1:    d = (v / 8'h0A) % 8'h0A;
         default: d = v % 8'h0A;
      endcase
      return telemetry_pkg::CH_ZERO + d;
   endfunction

   logic [5:0] q;
   logic [7:0] fv;
   logic [2:0] b;
   always_comb begin
      q  = pos_q - telemetry_pkg::HDR_LEN;
      b  = 3'(pos_q - telemetry_pkg::BITS_POS);
      fv = 8'h00;
      case (q[5:2])
         4'h0:    fv = smp_q.seq;
         4'h1:    fv = smp_q.temp;
         4'h2:    fv = smp_q.supply;
         4'h3:    fv = smp_q.ain1;
         4'h4:    fv = smp_q.ain2;
         default: fv = smp_q.radio;
      endcase
      beat.last = pos_q == telemetry_pkg::LAST_POS;
      if (pos_q == 6'h00) begin
         beat.ch = telemetry_pkg::CH_T;
      end else if (pos_q == 6'h01) begin
         beat.ch = telemetry_pkg::CH_HASH;
      end else if (pos_q < telemetry_pkg::BITS_POS) begin
         if (q[1:0] == 2'h3) begin
            beat.ch = telemetry_pkg::CH_COMMA;
         end else begin
            beat.ch = digit(fv, q[1:0]);
         end
      end else begin
         // six zeros, then the two live digits
         case (b)
            3'h6:    beat.ch = telemetry_pkg::CH_ZERO
                               + {7'h0, smp_q.aux};
            3'h7:    beat.ch = telemetry_pkg::CH_ZERO
                               + {7'h0, smp_q.prof};
            default: beat.ch = telemetry_pkg::CH_ZERO;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // report sequencer
   // ----------------------------------------------------------------
   always_comb begin
      st_d  = st_q;
      pos_d = pos_q;
      seq_d = seq_q;
      smp_d = smp_q;
      push  = 1'b0;
      case (st_q)
         telemetry_pkg::ST_IDLE: begin
            if (start) begin
               // one snapshot per report
               // 10-bit codes at a 5 V reference, top eight bits kept:
               // 51.2 counts per volt
               // sensor 10 mV/K gives 0.512 counts/K
               // supply over 3.7 gives 13.84 counts/V
               smp_d.seq    = seq_q;
               smp_d.temp   = temp_adc[ADC_W-1 -: 8];
               smp_d.supply = supply_adc[ADC_W-1 -: 8];
               smp_d.ain1   = header_analog_in_first[ADC_W-1 -: 8];
               smp_d.ain2   = header_analog_in_second[ADC_W-1 -: 8];
               smp_d.radio  = radio_connector[ADC_W-1 -: 8];
               smp_d.aux    = aux_digital_in_fourth;
               smp_d.prof   = ctrl_q[telemetry_pkg::CTRL_PROF_BIT];
               pos_d = '0;
               st_d  = telemetry_pkg::ST_EMIT;
            end
         end
         telemetry_pkg::ST_EMIT: begin
            push = fin_ready; // a full FIFO stalls the sequencer
            if (push) begin
               pos_d = pos_q + 6'h01;
               if (beat.last) begin
                  seq_d = seq_q + 8'h01;
                  st_d  = telemetry_pkg::ST_IDLE;
               end
            end
         end
         default: st_d = telemetry_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_q  <= telemetry_pkg::ST_IDLE;
         pos_q <= '0;
         seq_q <= '0;
         smp_q <= '0;
      end else begin
         st_q  <= st_d;
         pos_q <= pos_d;
         seq_q <= seq_d;
         smp_q <= smp_d;
      end
   end

   // ----------------------------------------------------------------
   // buffer and registered output stage
   // ----------------------------------------------------------------
   fifo_buf #(.W(9), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock     (clock),
      .rst       (rst),
      .in_valid  (push),
      .in_ready  (fin_ready),
      .in_data   (beat),
      .out_valid (fout_valid),
      .out_ready (fout_ready),
      .out_data  (fout)
   );

   always_comb begin
      fout_ready = !ov_q || char_ready;
      out_d      = out_q;
      ov_d       = ov_q && !char_ready;
      if (fout_valid && fout_ready) begin
         out_d = fout;
         ov_d  = 1'b1;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         out_q <= '0;
         ov_q  <= 1'b0;
      end else begin
         out_q <= out_d;
         ov_q  <= ov_d;
      end
   end
   assign char_data  = out_q.ch;
   assign char_last  = out_q.last;
   assign char_valid = ov_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_start;
      st_q == telemetry_pkg::ST_IDLE && start;
   endsequence
   sequence s_end;
      push && beat.last;
   endsequence

   property p_idle_off;
      st_q == telemetry_pkg::ST_IDLE && !en
         |=> st_q == telemetry_pkg::ST_IDLE;
   endproperty
   a_idle_off: assert property (p_idle_off)
      else $error("report while off");
   property p_hdr;
      push && pos_q == 6'h01 |-> beat.ch == telemetry_pkg::CH_HASH;
   endproperty
   a_hdr: assert property (p_hdr)
      else $error("bad header");
   property p_dig;
      push && pos_q > 6'h01 && pos_q < telemetry_pkg::BITS_POS
         && q[1:0] != 2'h3 |-> beat.ch >= 8'h30 && beat.ch <= 8'h39;
   endproperty
   a_dig: assert property (p_dig)
      else $error("non-digit");
   property p_seqf;
      push && pos_q == 6'h04 |-> beat.ch == 8'h30 + smp_q.seq % 8'h0A;
   endproperty
   a_seqf: assert property (p_seqf)
      else $error("seq field");
   property p_seq;
      s_end |=> seq_q == $past(seq_q) + 8'h01;
   endproperty
   a_seq: assert property (p_seq)
      else $error("seq step");
   property p_temp;
      s_start |=> smp_q.temp == $past(temp_adc[ADC_W-1 -: 8]);
   endproperty
   a_temp: assert property (p_temp)
      else $error("temp scale");
   property p_sup;
      s_start |=> smp_q.supply == $past(supply_adc[ADC_W-1 -: 8]);
   endproperty
   a_sup: assert property (p_sup)
      else $error("supply scale");
   property p_ain;
      s_start |=> smp_q.radio == $past(radio_connector[ADC_W-1 -: 8]);
   endproperty
   a_ain: assert property (p_ain)
      else $error("input scale");
   property p_prof;
      s_end |-> beat.ch == 8'h30 + {7'h0, smp_q.prof};
   endproperty
   a_prof: assert property (p_prof)
      else $error("profile digit");
   property p_aux;
      push && pos_q == 6'h20 |-> beat.ch == 8'h30 + {7'h0, smp_q.aux};
   endproperty
   a_aux: assert property (p_aux)
      else $error("aux digit");
   property p_bits;
      push && pos_q >= telemetry_pkg::BITS_POS && pos_q < 6'h20
         |-> beat.ch == 8'h30;
   endproperty
   a_bits: assert property (p_bits)
      else $error("unused digit");
   property p_comma;
      push && pos_q == 6'h05 |-> beat.ch == 8'h2C;
   endproperty
   a_comma: assert property (p_comma)
      else $error("comma");
   property p_hold;
      st_q == telemetry_pkg::ST_EMIT ##1 st_q == telemetry_pkg::ST_EMIT
         |-> $stable(smp_q);
   endproperty
   a_hold: assert property (p_hold)
      else $error("sample moved");
endmodule

`default_nettype wire

// ### test/encoder_model.sv
// stand-in for the packet encoder that takes the report characters
// assumes the framer's clock and reset; stall_len paces ready
`timescale 1ns/1ps
`default_nettype none

module encoder_model (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // character stream
   input  wire logic [7:0] char_data,
   input  wire logic       char_last,
   input  wire logic       char_valid,
   output logic            char_ready,
   // pacing, zero means always ready
   input  wire logic [7:0] stall_len
);
   logic [7:0] got_q[$];
   logic       last_q[$];
   logic [7:0] gap_q;

   // ------------------------------------------------------------------
   // take and pace
   // ------------------------------------------------------------------
   // a slow modem drops ready after each character, so the fifo fills
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         gap_q <= 8'h00;
         char_ready <= 1'b0;
      end else begin
         if (char_valid && char_ready) begin
            got_q.push_back(char_data);
            last_q.push_back(char_last);
         end
         if (char_valid && char_ready && stall_len != 8'h00) begin
            gap_q <= stall_len;
            char_ready <= 1'b0;
         end else if (gap_q > 8'h01) begin
            gap_q <= gap_q - 8'h01;
         end else begin
            gap_q <= 8'h00;
            char_ready <= 1'b1;
         end
      end
   end
endmodule

`default_nettype wire

// ### test/telemetry_text_framer_tb.sv
// self-checking bench of the telemetry text framer
// assumes the framer is built with a one-second tick of four cycles
`timescale 1ns/1ps
`default_nettype none

`define CHECK(got, exp, msg) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) begin \
         miscompares++; \
         $display("wrong value at %0t: %s", $time, msg); \
      end \
   end

module telemetry_text_framer_tb;
   localparam int unsigned ADC_W = 10;
   localparam int unsigned TICKS = 4;

   logic             clock;
   logic             rst;
   logic [7:0]       reg_addr;
   logic [31:0]      reg_wdata;
   logic             reg_wr;
   logic             reg_rd;
   logic [31:0]      reg_rdata;
   logic [ADC_W-1:0] adc_in[5];
   logic             aux_in;
   logic [7:0]       char_data;
   logic             char_last;
   logic             char_valid;
   logic             char_ready;
   logic [7:0]       stall_len;
   logic [ADC_W-1:0] set_a[5];
   logic [ADC_W-1:0] set_b[5];
   int               miscompares;
   int               samples_checked;
   int               spacing;

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   telemetry_text_framer #(
      .ADC_W      (ADC_W),
      .FIFO_DEPTH (16),
      .TICK_CYCLES(TICKS)
   ) uut (
      .clock                  (clock),
      .rst                    (rst),
      .reg_addr               (reg_addr),
      .reg_wdata              (reg_wdata),
      .reg_wr                 (reg_wr),
      .reg_rd                 (reg_rd),
      .reg_rdata              (reg_rdata),
      .temp_adc               (adc_in[0]),
      .supply_adc             (adc_in[1]),
      .header_analog_in_first (adc_in[2]),
      .header_analog_in_second(adc_in[3]),
      .radio_connector        (adc_in[4]),
      .aux_digital_in_fourth  (aux_in),
      .char_data              (char_data),
      .char_last              (char_last),
      .char_valid             (char_valid),
      .char_ready             (char_ready)
   );

   encoder_model enc (
      .clock     (clock),
      .rst       (rst),
      .char_data (char_data),
      .char_last (char_last),
      .char_valid(char_valid),
      .char_ready(char_ready),
      .stall_len (stall_len)
   );

   // ------------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------------
   task automatic summarize;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [7:0] a, input logic [31:0] exp,
                           input logic [31:0] mask);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      `CHECK(reg_rdata & mask, exp, "register read")
   endtask

   task automatic wait_chars(input int n);
      int i;
      for (i = 0; i < 4000 && enc.got_q.size() < n; i++) begin
         @(posedge clock);
         #1;
      end
      if (enc.got_q.size() < n) begin
         miscompares++;
         $display("wrong value at %0t: no characters", $time);
         summarize();
      end
   endtask

   task automatic apply(input logic [ADC_W-1:0] v[5], input logic aux);
      @(posedge clock);
      foreach (v[i]) adc_in[i] <= v[i];
      aux_in <= aux;
   endtask

   task automatic check_report(input int seq, input logic [ADC_W-1:0] v[5],
                               input logic aux, input logic prof);
      string      exp;
      int         f[5];
      logic [7:0] c;
      logic       l;
      foreach (v[i]) f[i] = int'(v[i] >> telemetry_pkg::ADC_SHIFT);
      exp = $sformatf("T#%03d,%03d,%03d,%03d,%03d,%03d,000000%0b%0b",
                      seq, f[0], f[1], f[2], f[3], f[4], aux, prof);
      wait_chars(34);
      for (int i = 0; i < 34; i++) begin
         c = enc.got_q.pop_front();
         l = enc.last_q.pop_front();
         `CHECK(c, exp[i], "report character")
         `CHECK(l, (i == 33), "last flag")
      end
   endtask

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      set_a = '{10'h3FF, 10'h000, 10'h0FC, 10'h190, 10'h02A};
      set_b = '{10'h200, 10'h2B4, 10'h3FC, 10'h004, 10'h0C8};
      miscompares = 0;
      samples_checked = 0;
      rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      adc_in = set_a;
      aux_in = 1'b0;
      stall_len = 8'h00;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      // reset values, read-only status, unmapped place
      reg_read(telemetry_pkg::REG_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
      reg_read(telemetry_pkg::REG_INTERVAL, 32'h0000_003C, 32'hFFFF_FFFF);
      reg_write(telemetry_pkg::REG_STATUS, 32'h0000_03FF);
      reg_write(8'h10, 32'hFFFF_FFFF);
      reg_read(telemetry_pkg::REG_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
      reg_read(8'h10, 32'h0000_0000, 32'hFFFF_FFFF);
      reg_write(telemetry_pkg::REG_INTERVAL, 32'h0000_0001);
      reg_read(telemetry_pkg::REG_INTERVAL, 32'h0000_0001, 32'hFFFF_FFFF);
      repeat (40) @(posedge clock);
      `CHECK(enc.got_q.size(), 0, "report while off")
      reg_write(telemetry_pkg::REG_CTRL, 32'h0000_0001);
      // change everything once the first report is under way
      wait_chars(1);
      apply(set_b, 1'b1);
      stall_len <= 8'h28;
      reg_write(telemetry_pkg::REG_CTRL, 32'h0000_0003);
      check_report(0, set_a, 1'b0, 1'b0);
      // stalled encoder: fifo fills, sequencer still busy
      wait_chars(1);
      reg_read(telemetry_pkg::REG_STATUS, 32'h0000_0101, 32'h0000_01FF);
      check_report(1, set_b, 1'b1, 1'b1);
      @(posedge clock);
      stall_len <= 8'h00;
      for (int k = 2; k < 258; k++) begin
         check_report(k % 256, set_b, 1'b1, 1'b1);
      end
      // a report under way completes, then nothing more
      reg_write(telemetry_pkg::REG_CTRL, 32'h0000_0000);
      repeat (200) @(posedge clock);
      `CHECK(enc.got_q.size() % 34, 0, "partial report")
      enc.got_q.delete();
      enc.last_q.delete();
      repeat (200) @(posedge clock);
      `CHECK(enc.got_q.size(), 0, "report after off")
      // interval of 20 ticks: report starts stand one interval apart
      reg_write(telemetry_pkg::REG_INTERVAL, 32'h0000_0014);
      reg_write(telemetry_pkg::REG_CTRL, 32'h0000_0001);
      wait_chars(1);
      for (spacing = 0; spacing < 200 && enc.got_q.size() < 35;
           spacing++) begin
         @(posedge clock);
         #1;
      end
      `CHECK(spacing, 20 * TICKS, "report spacing")
      if (spacing >= 200) begin
         summarize();
      end
      check_report(3, set_b, 1'b1, 1'b0);
      check_report(4, set_b, 1'b1, 1'b0);
      summarize();
   end
endmodule

`default_nettype wire
